// >>> pcpd_defines.vh
// constants for the paged configuration and power-down register bank
// Notes on behaviour
// - bit 7 or 0 write starts self-clearing reset
// - link page 6800h/6900h/6A00h select digital/link pages
// - link pointer split: 3h low, 4h high
// - pair-write disable 0: write both channels
// - disabled: channel select picks A or B
// - analog pointer 11h: 80h master, 0Fh converter
// - two mask sets; 55h bit 0 is only stored and read back
// - mask set choice follows 26h bit 5
// - mask set 1 at 20h and 21h
// - mask set 2 at 23h and 24h
// - converter mask: A in 7-4, B in 3-0
// - buffer mask: B in 7-6, A in 5-4
// - select 0 mask 1, 1 mask 2, reset 0
`ifndef PCPD_DEFINES_VH
`define PCPD_DEFINES_VH
`define ADDR_SW_RESET 8'h00
`define ADDR_LINK_PTR_LO 8'h03
`define ADDR_LINK_PTR_HI 8'h04
`define ADDR_PAIR_WRITE 8'h05
`define ADDR_ANALOG_PTR 8'h11
`define ADDR_MASK1_CONV 8'h20
`define ADDR_MASK1_BUF 8'h21
`define ADDR_MASK2_CONV 8'h23
`define ADDR_MASK2_BUF 8'h24
`define ADDR_SLEEP_CTRL 8'h26
`define ADDR_MASK_CTRL 8'h55
`define PAGE_MAIN_DIGITAL 16'h6800
`define PAGE_LINK_DIGITAL 16'h6900
`define PAGE_LINK_ANALOG 16'h6A00
`define PAGE_MASTER 8'h80
`define PAGE_CONVERTER 8'h0F
`define BIT_RESET_HI 7
`define BIT_RESET_LO 0
`define BIT_PAIR_DISABLE 0
`define BIT_SLEEP 7
`define BIT_IGNORE_PIN 6
`define BIT_MASK_SEL 5
`define BIT_MASK_CTRL 0
`define RESET_BYTE 8'h00
`define RESET_PULSE_CYCLES 4
`endif

// >>> sw_reset_pulse.v
// stretches a software reset request into a fixed-length pulse
`default_nettype none
module sw_reset_pulse #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire srst,
    input wire start,
    output reg busy_q
);
    reg [7:0] count_q;
    always @(posedge ref_clk) begin
        if (srst) begin
            count_q <= 8'h00;
            busy_q <= 1'b0;
        end else if (start) begin
            count_q <= WIDTH[7:0];
            busy_q <= 1'b1;
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
            busy_q <= (count_q != 8'h01);
        end else begin
            busy_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> paged_config_powerdown_regs.v
// general configuration and power-down mask register bank
`include "pcpd_defines.vh"
`default_nettype none
module paged_config_powerdown_regs #(
    parameter RESET_CYCLES = `RESET_PULSE_CYCLES
) (
    input wire ref_clk,
    input wire srst,
    input wire wrEn,
    input wire rdEn,
    input wire [7:0] addr,
    input wire [7:0] wrData,
    input wire channelSelectBit,
    output reg [7:0] rdData_q,
    output reg rdValid_q,
    output reg softResetActive_q,
    output reg [15:0] linkPagePointer_q,
    output reg [7:0] analogPagePointer_q,
    output reg pairWriteDisable_q,
    output reg writeChanA_q,
    output reg writeChanB_q,
    output reg masterPageSelected_q,
    output reg converterPageSelected_q,
    output reg mainDigitalPageSelected_q,
    output reg linkDigitalPageSelected_q,
    output reg linkAnalogPageSelected_q,
    output reg [3:0] convAPowerdown_q,
    output reg [3:0] convBPowerdown_q,
    output reg [1:0] bufAPowerdown_q,
    output reg [1:0] bufBPowerdown_q,
    output reg wholeChipSleep_q,
    output reg ignoreSleepPin_q
);
    reg [7:0] mask1Conv_q;
    reg [1:0] mask1BufA_q;
    reg [1:0] mask1BufB_q;
    reg [7:0] mask2Conv_q;
    reg [1:0] mask2BufA_q;
    reg [1:0] mask2BufB_q;
    reg maskSetSelect_q;
    reg maskControl_q;
    reg [7:0] rdData_d;
    wire masterPage;
    wire resetReq;
    wire resetBusy;

    assign masterPage = (analogPagePointer_q == `PAGE_MASTER);
    assign resetReq = wrEn && (addr == `ADDR_SW_RESET) &&
        (wrData[`BIT_RESET_HI] || wrData[`BIT_RESET_LO]);

    sw_reset_pulse #(
        .WIDTH(RESET_CYCLES)
    ) resetPulse (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(resetReq),
        .busy_q(resetBusy)
    );

    // register writes; reset register holds no state so it reads back zero
    always @(posedge ref_clk) begin
        if (srst || resetBusy) begin
            linkPagePointer_q <= {`RESET_BYTE, `RESET_BYTE};
            analogPagePointer_q <= `RESET_BYTE;
            pairWriteDisable_q <= 1'b0;
            mask1Conv_q <= `RESET_BYTE;
            mask1BufA_q <= 2'h0;
            mask1BufB_q <= 2'h0;
            mask2Conv_q <= `RESET_BYTE;
            mask2BufA_q <= 2'h0;
            mask2BufB_q <= 2'h0;
            maskSetSelect_q <= 1'b0;
            maskControl_q <= 1'b0;
            wholeChipSleep_q <= 1'b0;
            ignoreSleepPin_q <= 1'b0;
        end else if (wrEn) begin
            if (addr == `ADDR_LINK_PTR_LO) begin
                linkPagePointer_q[7:0] <= wrData;
            end else if (addr == `ADDR_LINK_PTR_HI) begin
                linkPagePointer_q[15:8] <= wrData;
            end else if (addr == `ADDR_PAIR_WRITE) begin
                pairWriteDisable_q <= wrData[`BIT_PAIR_DISABLE];
            end else if (addr == `ADDR_ANALOG_PTR) begin
                analogPagePointer_q <= wrData;
            end else if (masterPage) begin
                if (addr == `ADDR_MASK1_CONV) begin
                    mask1Conv_q <= wrData;
                end else if (addr == `ADDR_MASK1_BUF) begin
                    mask1BufB_q <= wrData[7:6];
                    mask1BufA_q <= wrData[5:4];
                end else if (addr == `ADDR_MASK2_CONV) begin
                    mask2Conv_q <= wrData;
                end else if (addr == `ADDR_MASK2_BUF) begin
                    mask2BufB_q <= wrData[7:6];
                    mask2BufA_q <= wrData[5:4];
                end else if (addr == `ADDR_SLEEP_CTRL) begin
                    wholeChipSleep_q <= wrData[`BIT_SLEEP];
                    ignoreSleepPin_q <= wrData[`BIT_IGNORE_PIN];
                    maskSetSelect_q <= wrData[`BIT_MASK_SEL];
                end else if (addr == `ADDR_MASK_CTRL) begin
                    maskControl_q <= wrData[`BIT_MASK_CTRL];
                end
            end
        end
    end

    // read mux; reserved and write-only bits read zero
    always @* begin
        rdData_d = 8'h00;
        if (addr == `ADDR_LINK_PTR_LO) begin
            rdData_d = linkPagePointer_q[7:0];
        end else if (addr == `ADDR_LINK_PTR_HI) begin
            rdData_d = linkPagePointer_q[15:8];
        end else if (addr == `ADDR_PAIR_WRITE) begin
            rdData_d = {7'h00, pairWriteDisable_q};
        end else if (addr == `ADDR_ANALOG_PTR) begin
            rdData_d = analogPagePointer_q;
        end else if (masterPage) begin
            if (addr == `ADDR_MASK1_CONV) begin
                rdData_d = mask1Conv_q;
            end else if (addr == `ADDR_MASK1_BUF) begin
                rdData_d = {mask1BufB_q, mask1BufA_q, 4'h0};
            end else if (addr == `ADDR_MASK2_CONV) begin
                rdData_d = mask2Conv_q;
            end else if (addr == `ADDR_MASK2_BUF) begin
                rdData_d = {mask2BufB_q, mask2BufA_q, 4'h0};
            end else if (addr == `ADDR_SLEEP_CTRL) begin
                rdData_d = {wholeChipSleep_q, ignoreSleepPin_q, maskSetSelect_q, 5'h00};
            end else if (addr == `ADDR_MASK_CTRL) begin
                rdData_d = {7'h00, maskControl_q};
            end
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
            softResetActive_q <= 1'b0;
            writeChanA_q <= 1'b0;
            writeChanB_q <= 1'b0;
            masterPageSelected_q <= 1'b0;
            converterPageSelected_q <= 1'b0;
            mainDigitalPageSelected_q <= 1'b0;
            linkDigitalPageSelected_q <= 1'b0;
            linkAnalogPageSelected_q <= 1'b0;
            convAPowerdown_q <= 4'h0;
            convBPowerdown_q <= 4'h0;
            bufAPowerdown_q <= 2'h0;
            bufBPowerdown_q <= 2'h0;
        end else begin
            rdData_q <= rdEn ? rdData_d : 8'h00;
            rdValid_q <= rdEn;
            softResetActive_q <= resetBusy || resetReq;
            writeChanA_q <= !pairWriteDisable_q || !channelSelectBit;
            writeChanB_q <= !pairWriteDisable_q || channelSelectBit;
            masterPageSelected_q <= masterPage;
            converterPageSelected_q <= (analogPagePointer_q == `PAGE_CONVERTER);
            mainDigitalPageSelected_q <= (linkPagePointer_q == `PAGE_MAIN_DIGITAL);
            linkDigitalPageSelected_q <= (linkPagePointer_q == `PAGE_LINK_DIGITAL);
            linkAnalogPageSelected_q <= (linkPagePointer_q == `PAGE_LINK_ANALOG);
            if (maskSetSelect_q) begin
                convAPowerdown_q <= mask2Conv_q[7:4];
                convBPowerdown_q <= mask2Conv_q[3:0];
                bufAPowerdown_q <= mask2BufA_q;
                bufBPowerdown_q <= mask2BufB_q;
            end else begin
                convAPowerdown_q <= mask1Conv_q[7:4];
                convBPowerdown_q <= mask1Conv_q[3:0];
                bufAPowerdown_q <= mask1BufA_q;
                bufBPowerdown_q <= mask1BufB_q;
            end
        end
    end
endmodule
`default_nettype wire

// >>> config_host_model.sv
// host model driving the register access port
`default_nettype none
module config_host_model (
    input wire logic ref_clk,
    input wire logic rdValid_q,
    input wire logic [7:0] rdData_q,
    output logic wrEn = 1'b0,
    output logic rdEn = 1'b0,
    output logic channelSelectBit = 1'b0,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] wrData = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        wrEn = 1'b1;
        addr = a;
        wrData = v;
        @(negedge ref_clk);
        wrEn = 1'b0;
        addr = ~a;
        wrData = ~v;
        @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        if (a == 8'h26 && v[7]) put(a, v & 8'h7F);
        put(a, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge ref_clk);
        rdEn = 1'b1;
        addr = a;
        @(negedge ref_clk);
        rdEn = 1'b0;
        addr = ~a;
        v = rdValid_q ? rdData_q : 8'hXX;
    endtask
    task automatic sel(input logic b);
        @(negedge ref_clk);
        channelSelectBit = b;
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> pcpd_checker.sv
// assertions on the register bank ports
`default_nettype none
module pcpd_checker #(parameter int RESET_CYCLES = 4) (
    input wire logic ref_clk, srst, wrEn, rdEn, channelSelectBit, softResetActive_q, pairWriteDisable_q,
    input wire logic writeChanA_q, writeChanB_q, masterPageSelected_q, converterPageSelected_q,
    input wire logic mainDigitalPageSelected_q, linkDigitalPageSelected_q, linkAnalogPageSelected_q,
    input wire logic [7:0] addr, wrData, rdData_q, analogPagePointer_q,
    input wire logic [15:0] linkPagePointer_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic live = wrEn && !softResetActive_q;
    property p_rst; live && addr == 8'h00 && (wrData[7] || wrData[0]) |=> softResetActive_q; endproperty
    a_rst: assert property (p_rst) else $error("soft reset not started");
    property p_len; $rose(softResetActive_q) |-> softResetActive_q[*5] ##1 !softResetActive_q; endproperty
    a_len: assert property (p_len) else $error("soft reset length");
    property p_lo; live && addr == 8'h03 |=> linkPagePointer_q[7:0] == $past(wrData)
        && $stable(linkPagePointer_q[15:8]); endproperty
    a_lo: assert property (p_lo) else $error("link pointer low byte");
    property p_rd; rdEn && !wrEn && !softResetActive_q && addr == 8'h04 |=> rdData_q == linkPagePointer_q[15:8];
    endproperty
    a_rd: assert property (p_rd) else $error("link pointer readback");
    // page decodes are registered one cycle behind the pointers
    property p_link; mainDigitalPageSelected_q == ($past(linkPagePointer_q) == 16'h6800)
        && linkDigitalPageSelected_q == ($past(linkPagePointer_q) == 16'h6900)
        && linkAnalogPageSelected_q == ($past(linkPagePointer_q) == 16'h6A00); endproperty
    a_link: assert property (p_link) else $error("link page decode");
    property p_ana; masterPageSelected_q == ($past(analogPagePointer_q) == 8'h80)
        && converterPageSelected_q == ($past(analogPagePointer_q) == 8'h0F); endproperty
    a_ana: assert property (p_ana) else $error("analog page decode");
    // channel enables still hold their reset value on the first edge after reset
    property p_pair; !$past(srst) && !$past(pairWriteDisable_q) |-> writeChanA_q && writeChanB_q; endproperty
    a_pair: assert property (p_pair) else $error("pair write");
    property p_chan; $past(pairWriteDisable_q) |-> writeChanB_q == $past(channelSelectBit)
        && writeChanA_q != writeChanB_q; endproperty
    a_chan: assert property (p_chan) else $error("single channel write");
endmodule
bind paged_config_powerdown_regs pcpd_checker #(.RESET_CYCLES(RESET_CYCLES)) chk_u (.ref_clk, .srst, .wrEn, .rdEn,
    .channelSelectBit, .softResetActive_q, .pairWriteDisable_q, .writeChanA_q, .writeChanB_q, .masterPageSelected_q,
    .converterPageSelected_q, .mainDigitalPageSelected_q, .linkDigitalPageSelected_q, .linkAnalogPageSelected_q,
    .addr, .wrData, .rdData_q, .analogPagePointer_q, .linkPagePointer_q);
`default_nettype wire

// >>> paged_config_powerdown_regs_bench.sv
// self-checking bench for the paged configuration register bank
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module paged_config_powerdown_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, srst = 1'b1;
    logic wrEn, rdEn, channelSelectBit, rdValid_q, softResetActive_q, pairWriteDisable_q, writeChanA_q;
    logic writeChanB_q, masterPageSelected_q, converterPageSelected_q, mainDigitalPageSelected_q;
    logic linkDigitalPageSelected_q, linkAnalogPageSelected_q, wholeChipSleep_q, ignoreSleepPin_q;
    logic [1:0] bufAPowerdown_q, bufBPowerdown_q;
    logic [3:0] convAPowerdown_q, convBPowerdown_q;
    logic [7:0] addr, wrData, rdData_q, analogPagePointer_q, d;
    logic [15:0] linkPagePointer_q;
    logic [7:0] pg [3] = '{8'h68, 8'h69, 8'h6A};
    logic [7:0] rs [2] = '{8'h80, 8'h01};
    int num_checks = 0, miscompares = 0, n;
    wire logic [13:0] pwr = {wholeChipSleep_q, ignoreSleepPin_q, convAPowerdown_q, convBPowerdown_q,
        bufAPowerdown_q, bufBPowerdown_q};
    always #5 ref_clk = ~ref_clk;
    config_host_model host_u (.ref_clk, .rdValid_q, .rdData_q, .wrEn, .rdEn, .channelSelectBit, .addr, .wrData);
    paged_config_powerdown_regs dut_u (.ref_clk, .srst, .wrEn, .rdEn, .addr, .wrData, .channelSelectBit, .rdData_q,
        .rdValid_q, .softResetActive_q, .linkPagePointer_q, .analogPagePointer_q, .pairWriteDisable_q, .writeChanA_q,
        .writeChanB_q, .masterPageSelected_q, .converterPageSelected_q, .mainDigitalPageSelected_q,
        .linkDigitalPageSelected_q, .linkAnalogPageSelected_q, .convAPowerdown_q, .convBPowerdown_q,
        .bufAPowerdown_q, .bufBPowerdown_q, .wholeChipSleep_q, .ignoreSleepPin_q);
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        `CHK("read", e, d)
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        srst = 1'b0;
        rc(8'h04, 8'h00);
        rc(8'h00, 8'h00);
        foreach (pg[i]) begin
            host_u.wr(8'h04, pg[i]);
            host_u.wr(8'h03, 8'h00);
            `CHK("link page", {i == 0, i == 1, i == 2}, {mainDigitalPageSelected_q, linkDigitalPageSelected_q, linkAnalogPageSelected_q})
        end
        rc(8'h04, 8'h6A);
        host_u.wr(8'h11, 8'h0F);
        `CHK("analog page", 2'b01, {masterPageSelected_q, converterPageSelected_q})
        host_u.wr(8'h20, 8'hA5);
        host_u.wr(8'h11, 8'h80);
        rc(8'h20, 8'h00);
        host_u.wr(8'h20, 8'h3C);
        host_u.wr(8'h21, 8'h90);
        host_u.wr(8'h23, 8'h5A);
        host_u.wr(8'h24, 8'h60);
        `CHK("mask set 1", 14'h03C6, pwr)
        host_u.wr(8'h26, 8'h20);
        `CHK("mask set 2", 14'h05A9, pwr)
        host_u.wr(8'h26, 8'hE0);
        `CHK("sleep bits", 14'h35A9, pwr)
        host_u.wr(8'h55, 8'h01);
        rc(8'h55, 8'h01);
        `CHK("pair write", 2'b11, {writeChanA_q, writeChanB_q})
        host_u.wr(8'h05, 8'h01);
        host_u.sel(1'b1);
        `CHK("channel B", 2'b01, {writeChanA_q, writeChanB_q})
        host_u.sel(1'b0);
        `CHK("channel A", 2'b10, {writeChanA_q, writeChanB_q})
        foreach (rs[i]) begin
            host_u.wr(8'h03, 8'h12);
            host_u.wr(8'h00, rs[i]);
            for (n = 0; n < 20 && softResetActive_q === 1'b1; n++) @(negedge ref_clk);
            `CHK("soft reset", 26'h0, {softResetActive_q, pairWriteDisable_q, linkPagePointer_q, analogPagePointer_q})
        end
        results;
    end
endmodule
`default_nettype wire
